// ### logic/pdt_timer.sv
/*
 * Prescaled down timer: an 8-bit downcounter fed by a 7-bit prescaler,
 * with zero flag, timer interrupt, wake request and an APB register slave.
 * Assumes one clock CORE_CLK at 250 MHz used as the internal clock, an
 * asynchronous active-high RST, and power mode pins from another domain.
 */
// Register access over APB was decided locally.
// Summary of operation
// - Counter always 8-bit, ticks on selected tap
// - Decrement to zero sets the zero flag
// - Interrupt when zero flag and enable set
// - Underflow 00h to FFh, count continues
// - Counter writable anytime, sets next period
// - Writing 00h or bit 7 sets flag
// - Counter write beats decrement to zero
// - Runs in WAIT, interrupt wakes device
// - STOP freezes counting, no wake
// - Init low holds prescaler 7Fh, counter frozen
// - Tap select divides by two to power
// - Prescaler reads seven bits, bit 7 zero
// - Interrupt enable resets to zero
// - Prescaler clocked by internal clock over twelve
// - Prescaler reloads 7Fh after reaching zero
// - Prescaler writable while init is one
// - Reset sets counter FFh, prescaler 7Fh
`timescale 1ns/1ps

module pdt_timer
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire pdt_pkg::pdt_apb_req_t APB_REQ,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire pdt_pkg::pdt_power_t POWER_MODE,
   output logic TIMER_IRQ,
   output logic IRQ,
   output logic WAKE
);
   import pdt_pkg::*;

   // Divider and prescaler state
   logic [3:0] div_reg; // Internal clock divide-by-twelve counter
   logic div_tick; // One-cycle enable at the divided rate
   logic [6:0] presc_reg; // Prescaler state
   logic [7:0] count_reg; // Timer counter state
   pdt_status_ctrl_t ctrl_reg; // Status/control register
   logic [PDT_IRQ_W-1:0] irq_status_reg; // Sticky event bits
   logic [PDT_IRQ_W-1:0] irq_mask_reg; // Event mask bits
   // Power mode synchronisers
   pdt_power_t power_meta_reg; // First stage, read only by the second
   pdt_power_t power_sync_reg; // Second stage, safe to use
   // Bus state
   logic ready_reg; // Answer phase flag
   logic [31:0] rdata_reg; // Captured read data
   logic slverr_reg; // Captured error answer
   logic timer_irq_reg; // Registered timer interrupt
   logic irq_reg; // Registered masked interrupt
   logic wake_reg; // Registered wake request
   // Decoded bus strobes
   logic [9:0] word_idx; // Word index of the address
   logic aligned; // Address is word aligned
   logic access_done; // Transfer completes at this edge
   logic wr_fire; // Write takes effect at this edge
   logic wr_presc; // Write to prescaler register
   logic wr_count; // Write to counter register
   logic wr_ctrl; // Write to status/control register
   logic wr_irq_status; // Write to interrupt status
   logic wr_irq_mask; // Write to interrupt mask
   logic mapped; // Address hits a register
   logic [31:0] rd_value; // Read mux result
   // Timer events
   logic run; // Counting allowed
   logic presc_tick; // Prescaler steps this cycle
   logic [6:0] tap_mask; // Low prescaler bits for the tap
   logic count_tick; // Counter steps this cycle
   logic hit_zero; // Counter decrements to zero
   logic underflow; // Counter passes 00h to FFh
   logic flag_set; // Any cause setting the zero flag
   logic flag_clear; // Software clearing the zero flag
   logic zero_next; // Next zero flag value
   logic [PDT_IRQ_W-1:0] irq_events; // Events for the sticky bits
   pdt_status_ctrl_t ctrl_wdata; // Written byte seen as control fields

   // Address decode and strobes
   assign word_idx = APB_REQ.paddr[PDT_ADDR_W-1:2];
   assign aligned = (APB_REQ.paddr[1:0] == PDT_ALIGN_ZERO);
   assign access_done = APB_REQ.psel & APB_REQ.penable & ready_reg;
   assign wr_fire = access_done & APB_REQ.pwrite & mapped;
   assign wr_presc = wr_fire & (word_idx == PDT_IDX_PRESCALER);
   assign wr_count = wr_fire & (word_idx == PDT_IDX_COUNTER);
   assign wr_ctrl = wr_fire & (word_idx == PDT_IDX_STATUS_CTRL);
   assign wr_irq_status = wr_fire & (word_idx == PDT_IDX_IRQ_STATUS);
   assign wr_irq_mask = wr_fire & (word_idx == PDT_IDX_IRQ_MASK);

   // Read mux; unused bits read as zero, reserved control bits read back as written
   always_comb
   begin
      rd_value = PDT_RDATA_ZERO;
      mapped = aligned;
      case (word_idx)
         PDT_IDX_PRESCALER:
         begin
            // Bit 7 always reads zero
            rd_value[6:0] = presc_reg;
         end
         PDT_IDX_COUNTER:
         begin
            rd_value[7:0] = count_reg;
         end
         PDT_IDX_STATUS_CTRL:
         begin
            rd_value[7:0] = ctrl_reg;
         end
         PDT_IDX_IRQ_STATUS:
         begin
            rd_value[PDT_IRQ_W-1:0] = irq_status_reg;
         end
         PDT_IDX_IRQ_MASK:
         begin
            rd_value[PDT_IRQ_W-1:0] = irq_mask_reg;
         end
         default:
         begin
            // Unmapped word answers with an error
            mapped = 1'b0;
         end
      endcase
      if (!aligned)
      begin
         rd_value = PDT_RDATA_ZERO;
      end
   end

   // APB answer: one wait state, then ready with data and error
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         ready_reg <= 1'b0;
         rdata_reg <= PDT_RDATA_ZERO;
         slverr_reg <= 1'b0;
      end
      else if (access_done)
      begin
         // Transfer ends; drop the answer
         ready_reg <= 1'b0;
         rdata_reg <= PDT_RDATA_ZERO;
         slverr_reg <= 1'b0;
      end
      else if (APB_REQ.psel & APB_REQ.penable)
      begin
         // Access phase: present the answer for the next edge
         ready_reg <= 1'b1;
         rdata_reg <= APB_REQ.pwrite ? PDT_RDATA_ZERO : rd_value;
         slverr_reg <= ~mapped;
      end
   end

   // Power mode pins cross into the core clock through two flops
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         power_meta_reg <= '0;
         power_sync_reg <= '0;
      end
      else
      begin
         power_meta_reg <= POWER_MODE;
         power_sync_reg <= power_meta_reg;
      end
   end

   // Divide the internal clock by twelve into an enable pulse
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         div_reg <= PDT_DIV_ZERO;
      end
      else if (div_reg == PDT_DIV_LAST)
      begin
         div_reg <= PDT_DIV_ZERO;
      end
      else
      begin
         div_reg <= div_reg + 4'h1;
      end
   end

   assign div_tick = (div_reg == PDT_DIV_LAST);

   // STOP freezes prescaler and counter, the divider runs on; WAIT has no effect here
   assign run = ctrl_reg.prescaler_init & ~power_sync_reg.stop_mode;
   assign presc_tick = div_tick & run;

   // Tap n fires once every two-to-the-n prescaler steps
   always_comb
   begin
      tap_mask = PDT_PRESCALER_ZERO;
      for (int i = 0; i < 7; i++)
      begin
         if (i < int'(ctrl_reg.tap_select))
         begin
            tap_mask[i] = 1'b1;
         end
      end
   end

   assign count_tick = presc_tick & ((presc_reg & tap_mask) == PDT_PRESCALER_ZERO);

   // Prescaler: held while init is low, writable while it is high
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         presc_reg <= PDT_PRESCALER_RESET;
      end
      else if (!ctrl_reg.prescaler_init)
      begin
         presc_reg <= PDT_PRESCALER_RESET;
      end
      else if (wr_presc)
      begin
         presc_reg <= APB_REQ.pwdata[6:0];
      end
      else if (presc_tick)
      begin
         if (presc_reg == PDT_PRESCALER_ZERO)
         begin
            presc_reg <= PDT_PRESCALER_RELOAD;
         end
         else
         begin
            presc_reg <= presc_reg - 7'h01;
         end
      end
   end

   // Counter: software write wins over a decrement in the same cycle
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         count_reg <= PDT_COUNTER_RESET;
      end
      else if (wr_count)
      begin
         count_reg <= APB_REQ.pwdata[7:0];
      end
      else if (count_tick)
      begin
         // Wraps from 00h to FFh and keeps counting
         count_reg <= count_reg - 8'h01;
      end
   end

   // Counter events, suppressed by a coinciding counter write
   assign hit_zero = count_tick & (count_reg == PDT_COUNTER_ONE) & ~wr_count;
   assign underflow = count_tick & (count_reg == PDT_COUNTER_ZERO) & ~wr_count;

   // Zero flag causes; hardware set wins over a software clear
   assign flag_set = hit_zero | underflow
      | (wr_count & (APB_REQ.pwdata[7:0] == PDT_COUNTER_ZERO))
      | (wr_ctrl & APB_REQ.pwdata[PDT_BIT_ZERO_FLAG]);
   // Only software ever clears it
   assign flag_clear = wr_ctrl & ~APB_REQ.pwdata[PDT_BIT_ZERO_FLAG];
   assign zero_next = flag_set | (ctrl_reg.zero_flag & ~flag_clear);

   // Written byte viewed through the register layout, no loose bit numbers
   assign ctrl_wdata = pdt_status_ctrl_t'(APB_REQ.pwdata[7:0]);

   // Status/control register
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         ctrl_reg <= PDT_STATUS_CTRL_RESET;
      end
      else
      begin
         ctrl_reg.zero_flag <= zero_next;
         if (wr_ctrl)
         begin
            // Control fields follow the written byte
            ctrl_reg.timer_irq_enable <= ctrl_wdata.timer_irq_enable;
            ctrl_reg.reserved_set_bit <= ctrl_wdata.reserved_set_bit;
            ctrl_reg.reserved_clear_bit <= ctrl_wdata.reserved_clear_bit;
            ctrl_reg.prescaler_init <= ctrl_wdata.prescaler_init;
            ctrl_reg.tap_select <= ctrl_wdata.tap_select;
         end
      end
   end

   // Sticky interrupt events
   assign irq_events[PDT_IRQ_BIT_ZERO] = hit_zero;
   assign irq_events[PDT_IRQ_BIT_UNDERFLOW] = underflow;

   // Sticky status, write one to clear, a new event wins
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         irq_status_reg <= PDT_IRQ_RESET;
      end
      else if (wr_irq_status)
      begin
         irq_status_reg <= (irq_status_reg & ~APB_REQ.pwdata[PDT_IRQ_W-1:0]) | irq_events;
      end
      else
      begin
         irq_status_reg <= irq_status_reg | irq_events;
      end
   end

   // Interrupt mask
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         irq_mask_reg <= PDT_IRQ_RESET;
      end
      else if (wr_irq_mask)
      begin
         irq_mask_reg <= APB_REQ.pwdata[PDT_IRQ_W-1:0];
      end
   end

   // Interrupt and wake outputs, all registered levels
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         timer_irq_reg <= 1'b0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end
      else
      begin
         // Level while flag and enable both stay set
         timer_irq_reg <= ctrl_reg.zero_flag & ctrl_reg.timer_irq_enable;
         irq_reg <= |(irq_status_reg & irq_mask_reg);
         // Wake from WAIT only; never from STOP
         wake_reg <= ctrl_reg.zero_flag & ctrl_reg.timer_irq_enable
            & power_sync_reg.wait_mode & ~power_sync_reg.stop_mode;
      end
   end

   // Outputs straight from flops
   assign PRDATA = rdata_reg;
   assign PREADY = ready_reg;
   assign PSLVERR = slverr_reg;
   assign TIMER_IRQ = timer_irq_reg;
   assign IRQ = irq_reg;
   assign WAKE = wake_reg;
endmodule

// ### shared/pdt_pkg.sv
/*
 * Constants, register map and field layouts of the prescaled down timer.
 * Assumes a 32-bit APB master that addresses one aligned word per register.
 */
package pdt_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [9:0] PDT_IDX_PRESCALER = 10'h0_0d2;
   localparam logic [9:0] PDT_IDX_COUNTER = 10'h0_0d3;
   localparam logic [9:0] PDT_IDX_STATUS_CTRL = 10'h0_0d4;
   localparam logic [9:0] PDT_IDX_IRQ_STATUS = 10'h0_0d5;
   localparam logic [9:0] PDT_IDX_IRQ_MASK = 10'h0_0d6;
   // Address bus width and word alignment
   localparam int PDT_ADDR_W = 12;
   localparam logic [1:0] PDT_ALIGN_ZERO = 2'h0;
   // Reset values
   localparam logic [6:0] PDT_PRESCALER_RESET = 7'h7f;
   localparam logic [6:0] PDT_PRESCALER_RELOAD = 7'h7f;
   localparam logic [6:0] PDT_PRESCALER_ZERO = 7'h00;
   localparam logic [7:0] PDT_COUNTER_RESET = 8'hff;
   localparam logic [7:0] PDT_COUNTER_ZERO = 8'h00;
   localparam logic [7:0] PDT_COUNTER_ONE = 8'h01;
   localparam logic [7:0] PDT_STATUS_CTRL_RESET = 8'h00;
   // Internal clock divider ahead of the prescaler
   localparam int PDT_INT_DIVIDE = 12;
   localparam logic [3:0] PDT_DIV_LAST = 4'(PDT_INT_DIVIDE - 1);
   localparam logic [3:0] PDT_DIV_ZERO = 4'h0;
   // Field positions of the status/control register
   localparam int PDT_BIT_ZERO_FLAG = 7;
   // Interrupt status bits (write one to clear) and mask bits
   localparam int PDT_IRQ_W = 2;
   localparam int PDT_IRQ_BIT_ZERO = 0;
   localparam int PDT_IRQ_BIT_UNDERFLOW = 1;
   localparam logic [PDT_IRQ_W-1:0] PDT_IRQ_RESET = 2'h0;
   // Read value of an unmapped word
   localparam logic [31:0] PDT_RDATA_ZERO = 32'h0000_0000;

   // Status/control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic zero_flag;
      logic timer_irq_enable;
      logic reserved_set_bit;
      logic reserved_clear_bit;
      logic prescaler_init;
      logic [2:0] tap_select;
   } pdt_status_ctrl_t;

   // APB request as seen by the slave
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [PDT_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } pdt_apb_req_t;

   // Power mode pins of the core
   typedef struct packed {
      logic wait_mode;
      logic stop_mode;
   } pdt_power_t;
endpackage

// ### tb/pdt_timer_assertions.sv
/* Port checker for the prescaled down timer.
   Sees only the top module ports; bound in at the foot of this file. */
`timescale 1ns/1ps
module pdt_timer_assertions
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire pdt_pkg::pdt_apb_req_t APB_REQ,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire pdt_pkg::pdt_power_t POWER_MODE,
   input wire logic TIMER_IRQ,
   input wire logic IRQ,
   input wire logic WAKE
);
   import pdt_pkg::*;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   // Completing read of the status/control word
   logic rd_st;
   assign rd_st = PREADY && !APB_REQ.pwrite && APB_REQ.paddr == 12'h350;
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   AST_READY_WAIT: assert property (APB_REQ.psel && APB_REQ.penable && !PREADY |=> PREADY)
      else $error("ready not one cycle after access");
   AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == PDT_RDATA_ZERO)
      else $error("read data outside transfer");
   AST_ERR_READY: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_UNALIGNED: assert property (PREADY && APB_REQ.paddr[1:0] != PDT_ALIGN_ZERO |-> PSLVERR)
      else $error("unaligned not refused");
   AST_PRESC_TOP: assert property (
      PREADY && !APB_REQ.pwrite && APB_REQ.paddr == 12'h348 |-> PRDATA[31:7] == '0)
      else $error("prescaler upper bits set");
   AST_IRQ_ON: assert property (rd_st && PRDATA[7:6] == 2'b11 |=> TIMER_IRQ)
      else $error("timer irq missing");
   AST_IRQ_OFF: assert property (rd_st && !PRDATA[6] |=> !TIMER_IRQ)
      else $error("timer irq while disabled");
   AST_WAKE_GATED: assert property (WAKE |-> TIMER_IRQ)
      else $error("wake without irq");
   AST_STOP_NO_WAKE: assert property (POWER_MODE.stop_mode [*4] |-> !WAKE)
      else $error("wake in stop");
endmodule

bind pdt_timer pdt_timer_assertions u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
   .APB_REQ(APB_REQ), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .POWER_MODE(POWER_MODE), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ), .WAKE(WAKE));

// ### tb/tb_top.sv
/* Self-checking bench of the prescaled down timer over APB.
   Assumes the design package and the bound port checker. */
`timescale 1ns/1ps
module tb_top;
   import pdt_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pdt_apb_req_t req = '0;
   pdt_power_t pm = '0;
   logic [31:0] prdata;
   logic pready, pslverr, tirq, irq, wake;
   logic [31:0] seed = 32'h0001_1497;
   logic [31:0] r, v;
   logic e;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   int d, t;

   pdt_timer u_dut (.CORE_CLK(clk), .RST(rst), .APB_REQ(req), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .POWER_MODE(pm), .TIMER_IRQ(tirq),
      .IRQ(irq), .WAKE(wake));

   // 250 MHz clock and a cycle count
   initial
   begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // Repeatable random source
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Cycles from run start to the first counter step at a tap
   function automatic int tap_cycles(input int tp);
      return PDT_INT_DIVIDE * (1 << tp);
   endfunction

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x)
      begin
         $display("Error %s expected %h seen %h", n, x, g);
         miscompares++;
      end
   endtask

   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      req <= '0;
      if (n >= 50)
      begin
         miscompares++;
         finish_test();
      end
      @(posedge clk);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, '0);
      chk($sformatf("read %h", a), x, r);
   endtask

   // Reads until the whole word matches, t returns the cycles taken
   task automatic poll(input logic [11:0] a, input logic [31:0] x);
      int k;
      t = cyc;
      r = 'x;
      for (k = 0; k < 2000 && r !== x; k++)
         apb(1'b0, a, '0);
      if (r !== x)
      begin
         miscompares++;
         finish_test();
      end
      t = cyc - t;
   endtask

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values
      rc(12'h348, 32'h0000_007f);
      rc(12'h34c, 32'h0000_00ff);
      rc(12'h350, 32'h0000_0000);
      // Refused places
      apb(1'b0, 12'h35c, '0);
      chk("unmapped err", 1, e);
      apb(1'b1, 12'h349, 32'h0000_0001);
      chk("unaligned err", 1, e);
      // Frozen counter takes random nonzero bytes, prescaler write ignored
      for (int i = 0; i < 4; i++)
      begin
         v = (xs() & 32'h0000_00ff) | 32'h0000_0001;
         apb(1'b1, 12'h34c, v);
         rc(12'h34c, v);
      end
      apb(1'b1, 12'h348, 32'h0000_0015);
      rc(12'h348, 32'h0000_007f);
      // Flag by software and interrupt level
      apb(1'b1, 12'h34c, '0);
      rc(12'h350, 32'h0000_0080);
      chk("timer irq disabled", 0, tirq);
      apb(1'b1, 12'h350, '0);
      rc(12'h350, 32'h0000_0000);
      apb(1'b1, 12'h350, 32'h0000_00c0);
      rc(12'h350, 32'h0000_00c0);
      chk("timer irq", 1, tirq);
      pm.wait_mode <= 1'b1;
      repeat (4) @(posedge clk);
      chk("wake", 1, wake);
      pm.stop_mode <= 1'b1;
      repeat (4) @(posedge clk);
      chk("wake stop", 0, wake);
      pm <= '0;
      apb(1'b1, 12'h350, 32'h0000_0040);
      // The interrupt output follows the flag one edge after the write
      @(posedge clk);
      chk("timer irq off", 0, tirq);
      // Division ratio of every tap
      for (int tp = 0; tp < 8; tp++)
      begin
         apb(1'b1, 12'h350, '0);
         apb(1'b1, 12'h34c, 32'h0000_0002);
         apb(1'b1, 12'h350, 32'h0000_0008 | tp);
         poll(12'h34c, 32'h0000_0001);
         d = tap_cycles(tp);
         chk("tap ratio", 1, t >= d - 14 && t <= d + 8);
      end
      // Underflow, interrupt status and mask
      apb(1'b1, 12'h350, '0);
      apb(1'b1, 12'h358, 32'h0000_0003);
      apb(1'b1, 12'h354, 32'h0000_0003);
      apb(1'b1, 12'h34c, 32'h0000_0001);
      apb(1'b1, 12'h350, 32'h0000_0008);
      poll(12'h34c, 32'h0000_00ff);
      rc(12'h350, 32'h0000_0088);
      rc(12'h354, 32'h0000_0003);
      chk("irq", 1, irq);
      poll(12'h34c, 32'h0000_00fe);
      apb(1'b1, 12'h358, '0);
      // The masked interrupt output follows the mask one edge later
      @(posedge clk);
      chk("irq masked", 0, irq);
      apb(1'b1, 12'h354, 32'h0000_0003);
      rc(12'h354, 32'h0000_0000);
      // Counter write on the very edge of a 01h to 00h step
      apb(1'b1, 12'h350, '0);
      apb(1'b1, 12'h34c, 32'h0000_0001);
      // The divider runs free from reset release at edge 20, so counter
      // steps fall where cyc reads 7 modulo 12; the second write below
      // then completes exactly on the first step after the run starts
      for (int k = 0; k < PDT_INT_DIVIDE && cyc % PDT_INT_DIVIDE != 0; k++)
         @(posedge clk);
      apb(1'b1, 12'h350, 32'h0000_0008);
      v = (xs() & 32'h0000_00f0) | 32'h0000_0008;
      apb(1'b1, 12'h34c, v);
      rc(12'h34c, v);
      rc(12'h350, 32'h0000_0008);
      rc(12'h354, 32'h0000_0000);
      // Stop freezes the count; prescaler writes still land, bit 7 reads zero
      pm.stop_mode <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, 12'h34c, '0);
      v = r;
      repeat (100) @(posedge clk);
      rc(12'h34c, v);
      v = xs();
      apb(1'b1, 12'h348, v);
      rc(12'h348, v & 32'h0000_007f);
      pm <= '0;
      finish_test();
   end
endmodule
